// ==== src/irq_ctrl_pkg.sv ====
/*
  Package for the maskable interrupt controller: register offsets, field
  positions, reset values, vector table, sequence timing and carrier types.
  Assumes a 200 MHz system clock and a CPU core that drives the strobes.
*/
package irq_ctrl_pkg;
  localparam logic [7:0] ENABLE_REG_LOW_OFS = 8'h3a;
  localparam logic [7:0] ENABLE_REG_HIGH_OFS = 8'h3b;
  localparam logic [7:0] LATCH_REG_LOW_OFS = 8'h3c;
  localparam logic [7:0] LATCH_REG_HIGH_OFS = 8'h3d;
  localparam int MASTER_BIT = 0;
  localparam int EF_LO = 4;
  localparam int IL_LO = 2;
  localparam int NUM_LEVELS = 16;
  localparam int TRAP_LEVEL = 2;
  localparam int WDOG_LEVEL = 3;
  localparam int SHARED_RX_LEVEL = 9;
  localparam int SHARED_EXT3_LEVEL = 14;
  localparam int SHARED_EXT5_LEVEL = 15;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] EF_MASK = 16'hfff0;
  localparam logic [15:0] IL_MASK = 16'hfffc;
  localparam logic [15:0] NMI_MASK = 16'h000c;
  localparam logic [15:0] VECTOR_TOP = 16'hfffe;
  localparam logic [1:0] STACK_PUSH_COUNT = 2'h3;
  localparam int ACCEPT_MACHINE_CYCLES = 8;
  localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
  localparam int ACCEPT_CLOCKS = ACCEPT_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
  localparam int MAX_LATENCY_CLOCKS = 38;
  localparam real CLK_PERIOD_NS = 5.0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic push;
    logic [15:0] addr;
    logic [7:0] data;
  } stack_op_type;
endpackage

// ==== src/irq_source_mux.sv ====
/*
  Selects one of two sources for each shared level and forms the per-level
  set pulses. Assumes request inputs are one-cycle pulses synchronous to clock.
*/
`timescale 1ns/1ps
module irq_source_mux
  import irq_ctrl_pkg::*;
(
  input wire logic [15:0] i_req,
  input wire logic i_sync_serial_irq,
  input wire logic i_timer_three_irq,
  input wire logic i_timer_five_irq,
  input wire logic [2:0] i_shared_source_select,
  output logic [15:0] o_set
);
  always_comb begin
    o_set = i_req & IL_MASK;
    o_set[SHARED_RX_LEVEL] = i_shared_source_select[0] ? i_sync_serial_irq
                                                       : i_req[SHARED_RX_LEVEL];
    o_set[SHARED_EXT3_LEVEL] = i_shared_source_select[1] ? i_timer_three_irq
                                                         : i_req[SHARED_EXT3_LEVEL];
    o_set[SHARED_EXT5_LEVEL] = i_shared_source_select[2] ? i_timer_five_irq
                                                         : i_req[SHARED_EXT5_LEVEL];
  end
endmodule

// ==== src/irq_priority.sv ====
/*
  Picks the pending level with the lowest number among the candidates.
  Assumes a pure combinational use by the controller.
*/
`timescale 1ns/1ps
module irq_priority
  import irq_ctrl_pkg::*;
(
  input wire logic [15:0] i_cand,
  output logic o_any,
  output logic [3:0] o_level
);
  always_comb begin
    o_any = 1'b0;
    o_level = 4'h0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (i_cand[i]) begin
        o_any = 1'b1;
        o_level = 4'(i);
      end
    end
  end
endmodule

// ==== src/maskable_interrupt_controller.sv ====
/*
  Maskable interrupt controller: request latches, enable flags, master enable,
  shared-source selection and the acceptance sequence toward the stack.
  Assumes the CPU core sequencer drives the register strobes, the instruction
  boundary pulse and the return pulses, and accepts the stack pushes.
*/
`timescale 1ns/1ps
module maskable_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire sfr_req_type i_sfr,
  output logic [7:0] o_sfr_rdata,
  input wire logic [15:0] i_req,
  input wire logic i_sync_serial_irq,
  input wire logic i_timer_three_irq,
  input wire logic i_timer_five_irq,
  input wire logic [2:0] i_shared_source_select,
  input wire logic i_insn_boundary,
  input wire logic [7:0] i_status_byte,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_sp,
  input wire logic i_return_maskable_insn,
  input wire logic i_return_nonmaskable_insn,
  input wire logic i_restored_master,
  output stack_op_type o_stack,
  output logic [15:0] o_sp_new,
  output logic o_sp_load,
  output logic [15:0] o_vector_addr,
  output logic o_pc_load,
  output logic o_accept_busy,
  output logic o_irq_pending,
  output logic o_master_irq_enable
);
  typedef enum logic [2:0] {IDLE, START, PUSH_PSW, PUSH_PCH, PUSH_PCL, WAIT_END, LOAD_PC}
    seq_state_type;

  logic [15:0] enable_r;
  logic [15:0] latch_r;
  logic [15:0] set_pulse;
  logic [15:0] cand;
  logic any_cand;
  logic [3:0] pick_level;
  logic [3:0] level_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [15:0] pc_r;
  logic [15:0] sp_r;
  logic [7:0] psw_r;
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic [15:0] latch_wmask;
  logic accept_start;

  irq_source_mux u_mux (
    .i_req(i_req),
    .i_sync_serial_irq(i_sync_serial_irq),
    .i_timer_three_irq(i_timer_three_irq),
    .i_timer_five_irq(i_timer_five_irq),
    .i_shared_source_select(i_shared_source_select),
    .o_set(set_pulse)
  );

  always_comb begin
    cand = latch_r & NMI_MASK;
    if (enable_r[MASTER_BIT]) begin
      cand = cand | (latch_r & enable_r & EF_MASK);
    end
  end

  irq_priority u_prio (
    .i_cand(cand),
    .o_any(any_cand),
    .o_level(pick_level)
  );

  assign accept_start = (state_r == IDLE) && any_cand && i_insn_boundary;

  always_comb begin
    latch_wmask = 16'hffff;
    if (i_sfr.wr && i_sfr.addr == LATCH_REG_LOW_OFS) begin
      latch_wmask[7:0] = i_sfr.wdata;
    end
    if (i_sfr.wr && i_sfr.addr == LATCH_REG_HIGH_OFS) begin
      latch_wmask[15:8] = i_sfr.wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      latch_r <= LATCH_RESET;
    end else begin
      latch_r <= (((latch_r & latch_wmask) & ~(accept_start ? (16'h0001 << pick_level)
                  : 16'h0000)) | set_pulse) & IL_MASK;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      enable_r <= ENABLE_RESET;
    end else begin
      if (i_sfr.wr && i_sfr.addr == ENABLE_REG_LOW_OFS) begin
        enable_r[7:0] <= i_sfr.wdata & EF_MASK[7:0] | {7'h00, i_sfr.wdata[MASTER_BIT]};
      end
      if (i_sfr.wr && i_sfr.addr == ENABLE_REG_HIGH_OFS) begin
        enable_r[15:8] <= i_sfr.wdata;
      end
      if (i_return_maskable_insn || i_return_nonmaskable_insn) begin
        enable_r[MASTER_BIT] <= i_restored_master;
      end
      if (accept_start && !cand[TRAP_LEVEL] && !cand[WDOG_LEVEL]) begin
        enable_r[MASTER_BIT] <= 1'b0;
      end else if (accept_start) begin
        enable_r[MASTER_BIT] <= 1'b0;
      end
    end
  end

  always_comb begin
    o_sfr_rdata = 8'h00;
    case (i_sfr.addr)
      ENABLE_REG_LOW_OFS: o_sfr_rdata = enable_r[7:0];
      ENABLE_REG_HIGH_OFS: o_sfr_rdata = enable_r[15:8];
      LATCH_REG_LOW_OFS: o_sfr_rdata = latch_r[7:0];
      LATCH_REG_HIGH_OFS: o_sfr_rdata = latch_r[15:8];
      default: o_sfr_rdata = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 6'h01;
    case (state_r)
      IDLE: begin
        cnt_nxt = 6'h00;
        if (accept_start) state_nxt = START;
      end
      START: state_nxt = PUSH_PSW;
      PUSH_PSW: state_nxt = PUSH_PCH;
      PUSH_PCH: state_nxt = PUSH_PCL;
      PUSH_PCL: state_nxt = WAIT_END;
      WAIT_END: if (cnt_r == 6'(ACCEPT_CLOCKS - 2)) state_nxt = LOAD_PC;
      LOAD_PC: state_nxt = IDLE;
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= IDLE;
      cnt_r <= 6'h00;
      level_r <= 4'h0;
      pc_r <= 16'h0000;
      sp_r <= 16'h0000;
      psw_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (accept_start) begin
        level_r <= pick_level;
        pc_r <= i_pc;
        sp_r <= i_sp;
        psw_r <= {i_status_byte[7:1], enable_r[MASTER_BIT]};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_stack <= '0;
      o_sp_new <= 16'h0000;
      o_sp_load <= 1'b0;
      o_vector_addr <= 16'h0000;
      o_pc_load <= 1'b0;
    end else begin
      o_stack <= '0;
      o_sp_load <= 1'b0;
      o_pc_load <= 1'b0;
      case (state_r)
        PUSH_PSW: o_stack <= '{push: 1'b1, addr: sp_r, data: psw_r};
        PUSH_PCH: o_stack <= '{push: 1'b1, addr: sp_r - 16'h0001, data: pc_r[15:8]};
        PUSH_PCL: begin
          o_stack <= '{push: 1'b1, addr: sp_r - 16'h0002, data: pc_r[7:0]};
          o_sp_new <= sp_r - {14'h0000, STACK_PUSH_COUNT};
          o_sp_load <= 1'b1;
        end
        LOAD_PC: begin
          o_vector_addr <= VECTOR_TOP - {11'h000, level_r, 1'b0};
          o_pc_load <= 1'b1;
        end
        default: o_stack <= '0;
      endcase
    end
  end

  assign o_accept_busy = (state_r != IDLE);
  assign o_irq_pending = any_cand;
  assign o_master_irq_enable = enable_r[MASTER_BIT];

  // Assertions.
  a_master_blocks: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept_start && !enable_r[MASTER_BIT] |-> (cand & EF_MASK) == 16'h0000)
    else $error("maskable accepted with master clear");
  a_accept_clears: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept_start |=> !enable_r[MASTER_BIT])
    else $error("master not cleared on acceptance");
  sequence s_pushes;
    o_stack.push [*3];
  endsequence
  a_push_order: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept_start |-> ##3 s_pushes ##0 o_sp_load)
    else $error("push sequence wrong");
  a_accept_len: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept_start |-> ##(ACCEPT_CLOCKS + 1) o_pc_load)
    else $error("acceptance length wrong");
  a_latch_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    latch_r[5] && !accept_start && latch_wmask[5] |=> latch_r[5])
    else $error("latch dropped");
  a_latch_set: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    set_pulse[8] |=> latch_r[8])
    else $error("request lost");
  a_nmi_free: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    latch_r[WDOG_LEVEL] && !o_accept_busy && i_insn_boundary && !latch_r[TRAP_LEVEL]
    |-> accept_start && pick_level == 4'(WDOG_LEVEL))
    else $error("non-maskable not taken");
  a_return_restore: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_return_maskable_insn && !accept_start |=> enable_r[MASTER_BIT] == $past(i_restored_master))
    else $error("master not restored");
endmodule

// ==== tb/cpu_core_model.sv ====
/*
  Core sequencer model: instruction boundary pulses, program counter and
  stack pointer. Assumes the controller's load strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
module cpu_core_model
  import irq_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_sp_load,
  input wire logic [15:0] i_sp_new,
  input wire logic i_pc_load,
  input wire logic [15:0] i_vector_addr,
  output logic o_insn_boundary,
  output logic [15:0] o_pc,
  output logic [15:0] o_sp
);
  logic [1:0] cnt_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  assign o_insn_boundary = (cnt_r == 2'h3) && !i_srst;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pc <= 16'h1234;
      o_sp <= 16'h00f0;
    end else begin
      if (i_pc_load) o_pc <= i_vector_addr;
      if (i_sp_load) o_sp <= i_sp_new;
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the interrupt controller: registers, shared
  sources, acceptance and return. Assumes the core model beside it.
*/
`timescale 1ns/1ps
module testbench
  import irq_ctrl_pkg::*;
;
  typedef struct {logic [15:0] ef, rq, vec, lat; logic acc;} row_type;
  logic ref_clk, srst, ss, t3, t5, rm, rn, rmst, bnd, sp_ld, pc_ld, busy, pend, mst;
  logic [2:0] sel;
  logic [15:0] req, pc, sp, sp_new, vec;
  logic [7:0] rdata;
  sfr_req_type sfr;
  stack_op_type stk;
  int fails = 0;
  int samples_checked = 0;
  row_type rows [6] = '{
    '{16'h0010, 16'h0010, 16'hfff6, 16'h0000, 1'b1},
    '{16'h0100, 16'h0100, 16'hffee, 16'h0000, 1'b1},
    '{16'h8000, 16'h8000, 16'hffe0, 16'h0000, 1'b1},
    '{16'h0840, 16'h0840, 16'hfff2, 16'h0800, 1'b1},
    '{16'h0020, 16'h0100, 16'h0000, 16'h0100, 1'b0},
    '{16'h0000, 16'h0004, 16'hfffa, 16'h0000, 1'b1}};

  maskable_interrupt_controller dut (.i_ref_clk(ref_clk), .i_srst(srst), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .i_req(req), .i_sync_serial_irq(ss), .i_timer_three_irq(t3),
    .i_timer_five_irq(t5), .i_shared_source_select(sel), .i_insn_boundary(bnd),
    .i_status_byte(8'h5a), .i_pc(pc), .i_sp(sp), .i_return_maskable_insn(rm),
    .i_return_nonmaskable_insn(rn), .i_restored_master(rmst), .o_stack(stk),
    .o_sp_new(sp_new), .o_sp_load(sp_ld), .o_vector_addr(vec), .o_pc_load(pc_ld),
    .o_accept_busy(busy), .o_irq_pending(pend), .o_master_irq_enable(mst));
  cpu_core_model core (.i_ref_clk(ref_clk), .i_srst(srst), .i_sp_load(sp_ld),
    .i_sp_new(sp_new), .i_pc_load(pc_ld), .i_vector_addr(vec), .o_insn_boundary(bnd),
    .o_pc(pc), .o_sp(sp));

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    sfr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    sfr.rd = 1'b1;
    sfr.addr = a;
    #1;
    chk("rdata", {8'h0, rdata}, {8'h0, e});
    sfr.rd = 1'b0;
  endtask
  task automatic pulse(input logic [15:0] r, input logic [2:0] a);
    @(negedge ref_clk);
    req = r;
    {ss, t3, t5} = a;
    @(negedge ref_clk);
    req = 16'h0;
    {ss, t3, t5} = 3'h0;
  endtask
  task automatic take(input logic [15:0] v);
    int n;
    logic [15:0] pc0, sp0;
    logic m0;
    n = 0;
    pc0 = pc;
    sp0 = sp;
    m0 = mst;
    chk("pend", {15'h0, pend}, 16'h1);
    while (stk.push !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("in_time", {15'h0, n <= 41}, 16'h1);
    chk("psw_addr", stk.addr, sp0);
    chk("psw", {8'h0, stk.data}, {8'h0, 8'h5a | {7'h0, m0}});
    @(posedge ref_clk);
    #1;
    chk("pch_addr", stk.addr, sp0 - 16'h1);
    chk("pch", {8'h0, stk.data}, {8'h0, pc0[15:8]});
    @(posedge ref_clk);
    #1;
    chk("pcl_addr", stk.addr, sp0 - 16'h2);
    chk("pcl", {8'h0, stk.data}, {8'h0, pc0[7:0]});
    chk("sp_new", {sp_new[14:0], sp_ld}, {sp0[14:0] - 15'h3, 1'b1});
    n = 0;
    while (pc_ld !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("load_gap", 16'(n), 16'h1c);
    chk("vector", vec, v);
    chk("master", {15'h0, mst}, 16'h0);
  endtask
  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fails++;
    results();
  end
  initial begin
    {srst, ss, t3, t5, rm, rn, rmst, sel, req} = {1'b1, 9'h0, 16'h0};
    sfr = '0;
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    for (int a = 8'h3a; a < 8'h3f; a++) rd(8'(a), 8'h00);
    wr(8'h3c, 8'hff);
    wr(8'h3d, 8'hff);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    wr(8'h3b, 8'ha5);
    wr(8'h3a, 8'hfe);
    rd(8'h3a, 8'hf0);
    rd(8'h3b, 8'ha5);
    wr(8'h3b, 8'h00);
    wr(8'h3a, 8'h00);
    $display("register test done");
    foreach (rows[i]) begin
      wr(8'h3a, 8'h00);
      wr(8'h3b, rows[i].ef[15:8]);
      wr(8'h3a, rows[i].ef[7:0]);
      pulse(rows[i].rq, 3'h0);
      if (rows[i].ef != 16'h0) begin
        repeat (40) @(negedge ref_clk);
        chk("busy", {15'h0, busy}, 16'h0);
        rd(8'h3c, rows[i].rq[7:0]);
        rd(8'h3d, rows[i].rq[15:8]);
        wr(8'h3a, rows[i].ef[7:0] | 8'h01);
      end
      if (rows[i].acc) take(rows[i].vec);
      else begin
        repeat (40) @(negedge ref_clk);
        chk("busy", {15'h0, busy}, 16'h0);
        chk("pend", {15'h0, pend}, 16'h0);
      end
      rd(8'h3c, rows[i].lat[7:0]);
      rd(8'h3d, rows[i].lat[15:8]);
      wr(8'h3a, 8'h00);
      wr(8'h3c, 8'h0c);
      wr(8'h3d, 8'h00);
      $display("row %0d done", i);
    end
    pulse(16'h0, 3'h7);
    rd(8'h3d, 8'h00);
    sel = 3'h7;
    pulse(16'h0, 3'h7);
    rd(8'h3d, 8'hc2);
    wr(8'h3d, 8'h00);
    pulse(16'hc200, 3'h0);
    rd(8'h3d, 8'h00);
    $display("shared source test done");
    @(negedge ref_clk);
    {rm, rmst} = 2'h3;
    @(negedge ref_clk);
    {rm, rmst} = 2'h0;
    chk("master", {15'h0, mst}, 16'h1);
    rn = 1'b1;
    @(negedge ref_clk);
    rn = 1'b0;
    chk("master", {15'h0, mst}, 16'h0);
    $display("return test done");
    wr(8'h3b, 8'hff);
    pulse(16'h0100, 3'h0);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    rd(8'h3b, 8'h00);
    rd(8'h3d, 8'h00);
    $display("second reset test done");
    results();
  end
endmodule
